// ### shpc_assertions.sv
`timescale 1ns/1ns
module shpc_checker
(
   // clock and reset
   input wire clock_i,
   input wire nrst_i,
   // watched ports
   input wire master_i,
   input wire flow_ctrl_i,
   input wire run_i,
   input wire [7:0] clock_divider_modulus_i,
   input wire prescaler_bypass_i,
   input wire [1:0] filter_mode_i,
   input wire scl_i,
   input wire scl_o,
   input wire scl_oe_o,
   input wire host_request_i,
   input wire host_request_o,
   input wire scl_filt_o,
   input wire busy_o
);
   reg [15:0] lo_q, rq_q, st_q;
   reg sc_q;
   wire [15:0] half = ({8'h00, clock_divider_modulus_i} + 16'h1)
      * (prescaler_bypass_i ? 16'h1 : 16'h8);
   wire [15:0] acc = filter_mode_i[1] ? 16'hC : {13'h0, filter_mode_i, 1'h0} * 16'h3;
   always @(posedge clock_i or negedge nrst_i)
      if (!nrst_i)
      begin
         lo_q <= 16'h0;
         rq_q <= 16'h0;
         st_q <= 16'h0;
         sc_q <= 1'h1;
      end
      else
      begin
         lo_q <= scl_oe_o ? lo_q + 16'h1 : 16'h0;
         rq_q <= host_request_i ? rq_q + 16'h1 : 16'h0;
         st_q <= (scl_i == sc_q) ? st_q + 16'h1 : 16'h0;
         sc_q <= scl_i;
      end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_low_len:
      assert property ($fell(scl_oe_o) |-> lo_q == half) else $error("low len");
   a_req_wait:
      assert property (master_i && flow_ctrl_i && $rose(scl_oe_o)
         |-> rq_q >= half) else $error("early clock");
   a_spike_reject:
      assert property ($changed(scl_filt_o) |-> st_q >= acc) else $error("spike");
   a_req_drop:
      assert property (!master_i && flow_ctrl_i && $fell(scl_filt_o)
         && $past(host_request_o) |-> !host_request_o)
         else $error("request kept");
   a_req_hold:
      assert property (!master_i && host_request_o && $rose(scl_filt_o)
         |-> host_request_o [*5]) else $error("request short");
   a_drive_low:
      assert property (scl_oe_o |-> !scl_o) else $error("drive level");
   a_idle_release:
      assert property (!busy_o |-> !scl_oe_o) else $error("idle drive");
   a_busy_start:
      assert property (master_i && run_i && !busy_o |=> busy_o) else $error("start");
   cover property ($fell(scl_oe_o));
   cover property ($fell(host_request_o));
   cover property ($rose(scl_filt_o));
endmodule
bind shpc_i2c_clock_gen shpc_checker chk (.*);

// ### shpc_consts.vh
`ifndef SHPC_CONSTS_VH
`define SHPC_CONSTS_VH
`define SHPC_CLK_NS 8
`define SHPC_PRESCALE 8
`define SHPC_FILT_BYPASS 2'h0
`define SHPC_FILT_NARROW 2'h1
`define SHPC_FILT_WIDE 2'h2
`define SHPC_NARROW_NS 50
`define SHPC_WIDE_NS 100
// accept lengths in core cycles: ceil(ns / clock period)
`define SHPC_NARROW_CYC 5'h07
`define SHPC_WIDE_CYC 5'h0D
`define SHPC_HOLD_NARROW_NS 80
`define SHPC_HOLD_WIDE_NS 135
`define SHPC_HOLD_BYP_NS 30
// request hold in core cycles: 2 + ceil(ns / clock period)
`define SHPC_HOLD_BYP_CYC 5'h06
`define SHPC_HOLD_NAR_CYC 5'h0C
`define SHPC_HOLD_WIDE_CYC 5'h13
`endif

// ### shpc_glitch_filter.v
`timescale 1ns/1ns
`include "shpc_consts.vh"
module shpc_glitch_filter
(
   // clock and reset
   input wire clock_i,
   input wire nrst_i,
   // control
   input wire [1:0] filter_mode_i,
   // line
   input wire line_i,
   output reg line_o
);
   reg [1:0] sync_q;
   reg [4:0] cnt_q;
   reg [4:0] limit;

   always @*
   begin
      case (filter_mode_i)
         `SHPC_FILT_NARROW: limit = `SHPC_NARROW_CYC;
         `SHPC_FILT_WIDE: limit = `SHPC_WIDE_CYC;
         default: limit = 5'h00;
      endcase
   end

   // level must persist past spike width before it is accepted
   always @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sync_q <= 2'h3;
         cnt_q <= 5'h00;
         line_o <= 1'b1;
      end
      else
      begin
         sync_q <= {sync_q[0], line_i};
         if (sync_q[1] == line_o)
            cnt_q <= 5'h00;
         else if (cnt_q >= limit)
         begin
            line_o <= sync_q[1];
            cnt_q <= 5'h00;
         end
         else
            cnt_q <= cnt_q + 5'h01;
      end
   end
endmodule

// ### shpc_host_model.sv
`timescale 1ns/1ns
module shpc_host_model
(
   // line and request
   input wire scl_oe_i,
   output wire scl_line_o,
   output reg host_request_o
);
   reg drv_low = 1'b0;
   initial host_request_o = 1'b0;
   // open-drain clock line with pull-up
   assign scl_line_o = !(scl_oe_i || drv_low);
   task pulse(input integer ns);
   begin
      drv_low = 1'b1;
      #ns;
      drv_low = 1'b0;
   end
   endtask
endmodule

// ### shpc_i2c_clock_gen.v
`timescale 1ns/1ns
`include "shpc_consts.vh"
module shpc_i2c_clock_gen
(
   // clock and reset
   input wire clock_i,
   input wire nrst_i,
   // control
   input wire master_i,
   input wire flow_ctrl_i,
   input wire run_i,
   input wire [7:0] clock_divider_modulus_i,
   input wire prescaler_bypass_i,
   input wire [1:0] filter_mode_i,
   input wire slave_ready_i,
   // bus pins
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe_o,
   input wire host_request_i,
   output reg host_request_o,
   // status
   output reg scl_filt_o,
   output reg busy_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_RUN = 2'h2;

   reg [1:0] state_q;
   reg [1:0] req_sync_q;
   reg [7:0] div_q;
   reg [2:0] pre_q;
   reg phase_q;
   reg scl_prev_q;
   reg [4:0] hold_q;
   reg [4:0] hold_len;
   wire scl_f;
   wire tick;
   wire scl_edge;

   shpc_glitch_filter u_scl_filter
   (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .filter_mode_i(filter_mode_i),
      .line_i(scl_i),
      .line_o(scl_f)
   );

   // prescaler then divider give one half period per tick
   assign tick = (div_q == 8'h00) &&
      (prescaler_bypass_i || pre_q == 3'h7);
   assign scl_edge = scl_f != scl_prev_q;

   always @*
   begin
      case (filter_mode_i)
         `SHPC_FILT_NARROW: hold_len = `SHPC_HOLD_NAR_CYC;
         `SHPC_FILT_WIDE: hold_len = `SHPC_HOLD_WIDE_CYC;
         default: hold_len = `SHPC_HOLD_BYP_CYC;
      endcase
   end

   always @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_q <= ST_IDLE;
         req_sync_q <= 2'h0;
         div_q <= 8'h00;
         pre_q <= 3'h0;
         phase_q <= 1'b0;
         scl_prev_q <= 1'b1;
         hold_q <= 5'h00;
         scl_o <= 1'b1;
         scl_oe_o <= 1'b0;
         host_request_o <= 1'b0;
         scl_filt_o <= 1'b1;
         busy_o <= 1'b0;
      end
      else
      begin
         req_sync_q <= {req_sync_q[0], host_request_i};
         scl_prev_q <= scl_f;
         scl_filt_o <= scl_f;
         // half period = (modulus+1) x prescale core periods, or modulus+1 with prescaler bypass
         if (state_q == ST_IDLE)
         begin
            div_q <= clock_divider_modulus_i;
            pre_q <= 3'h0;
         end
         else if (prescaler_bypass_i || pre_q == 3'h7)
         begin
            pre_q <= 3'h0;
            if (div_q == 8'h00)
               div_q <= clock_divider_modulus_i;
            else
               div_q <= div_q - 8'h01;
         end
         else
            pre_q <= pre_q + 3'h1;
         case (state_q)
            ST_IDLE:
            begin
               phase_q <= 1'b0;
               scl_o <= 1'b1;
               scl_oe_o <= 1'b0;
               busy_o <= 1'b0;
               if (master_i && run_i)
               begin
                  state_q <= ST_WAIT;
                  busy_o <= 1'b1;
               end
            end
            ST_WAIT:
            begin
               // half period delay after request seen
               if (!run_i)
                  state_q <= ST_IDLE;
               else if (!flow_ctrl_i || req_sync_q[1])
               begin
                  if (tick)
                     state_q <= ST_RUN;
               end
               else
               begin
                  div_q <= clock_divider_modulus_i;
                  pre_q <= 3'h0;
               end
            end
            ST_RUN:
            begin
               if (tick)
               begin
                  phase_q <= ~phase_q;
                  scl_o <= phase_q;
                  scl_oe_o <= ~phase_q;
                  if (phase_q && !run_i)
                     state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         // slave flow control
         if (master_i || !flow_ctrl_i)
         begin
            host_request_o <= 1'b0;
            hold_q <= 5'h00;
         end
         else if (scl_edge)
         begin
            hold_q <= hold_len;
            if (!scl_f)
               host_request_o <= 1'b0;
         end
         else if (hold_q != 5'h00)
            hold_q <= hold_q - 5'h01;
         else
            host_request_o <= slave_ready_i;
      end
   end
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
   reg clock_i = 1'b0;
   reg nrst_i = 1'b0;
   reg master = 1'b0, run = 1'b0, rdy = 1'b0, byp = 1'b1;
   reg [7:0] mod = 8'h02;
   reg [1:0] fmode = 2'h0;
   wire line, req_in, scl_o, oe, req, filt, busy;
   integer failures = 0, checks = 0, n, h;
   always #4 clock_i = !clock_i;
   shpc_host_model host (.scl_oe_i(oe), .scl_line_o(line), .host_request_o(req_in));
   shpc_i2c_clock_gen uut (.clock_i(clock_i), .nrst_i(nrst_i), .master_i(master),
      .flow_ctrl_i(1'b1), .run_i(run), .clock_divider_modulus_i(mod),
      .prescaler_bypass_i(byp), .filter_mode_i(fmode), .slave_ready_i(rdy),
      .scl_i(line), .scl_o(scl_o), .scl_oe_o(oe), .host_request_i(req_in),
      .host_request_o(req), .scl_filt_o(filt), .busy_o(busy));
   task check(input [15:0] seen, input [15:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task print_verdict;
   begin
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   task wait_oe(input v);
   begin
      n = 0;
      while (oe !== v && n < 5000)
      begin
         @(negedge clock_i);
         n = n + 1;
      end
   end
   endtask
   task t_master(input [7:0] m, input b);
   begin
      mod = m;
      byp = b;
      h = (m + 1) * (b ? 1 : 8);
      master = 1'b1;
      run = 1'b1;
      repeat (40) @(negedge clock_i);
      check(oe, 1'b0);
      host.host_request_o = 1'b1;
      wait_oe(1'b1);
      check(n >= h, 1'b1);
      wait_oe(1'b0);
      check(n, h);
      run = 1'b0;
      repeat (4 * h + 20) @(negedge clock_i);
      check({busy, oe}, 2'h0);
      host.host_request_o = 1'b0;
   end
   endtask
   task t_slave;
   begin
      master = 1'b0;
      fmode = 2'h2;
      rdy = 1'b1;
      repeat (30) @(negedge clock_i);
      check(req, 1'b1);
      host.pulse(48);
      repeat (30) @(negedge clock_i);
      check({filt, req}, 2'h3);
      fork
         host.pulse(400);
         begin
            repeat (30) @(negedge clock_i);
            check(req, 1'b0);
         end
      join
   end
   endtask
   initial
   begin
      repeat (10) @(negedge clock_i);
      nrst_i = 1'b1;
      t_master(8'h02, 1'b1);
      t_master(8'h05, 1'b0);
      t_master(8'hFF, 1'b0);
      t_slave;
      print_verdict;
   end
   initial
   begin
      #400000;
      failures = failures + 1;
      print_verdict;
   end
endmodule
